/* File: core/pm_msi_pkg.sv */
// constants and carriers for the port power management and message interrupt registers
`default_nettype none
package pm_msi_pkg;
   localparam logic [7:0]  OFS_POWER_CTRL_STATUS   = 8'hC4;
   localparam logic [7:0]  OFS_IRQ_MSG_CAP_CTRL    = 8'hD0;
   localparam logic [7:0]  OFS_IRQ_MSG_LOWER_ADDR  = 8'hD4;
   localparam logic [7:0]  OFS_IRQ_MSG_UPPER_ADDR  = 8'hD8;
   localparam logic [7:0]  OFS_IRQ_MSG_PAYLOAD     = 8'hDC;
   localparam int          POS_POWER_STATE         = 0;
   localparam int          POS_CONTEXT_KEEP        = 3;
   localparam int          POS_WAKE_ENABLE         = 8;
   localparam int          POS_WAKE_FLAG           = 15;
   localparam int          POS_IRQ_ENABLE          = 16;
   localparam int          POS_WIDE_ADDR           = 23;
   localparam logic [1:0]  STATE_FULL_ON           = 2'h0;
   localparam logic [1:0]  STATE_HOT_OFF           = 2'h3;
   localparam logic        RST_CONTEXT_KEEP        = 1'h1;
   localparam logic [7:0]  CAPABILITY_IDENTIFIER   = 8'h05;
   localparam logic [7:0]  NEXT_CAPABILITY_LINK    = 8'h00;
   localparam logic [2:0]  MULTI_MSG_CAPABLE       = 3'h0;
   localparam logic [2:0]  MULTI_MSG_ENABLE        = 3'h0;
   localparam logic        WIDE_ADDRESS_CAPABLE    = 1'h1;

   typedef struct packed {
      logic        valid;
      logic [63:0] addr;
      logic        wide;
      logic [31:0] data;
   } msg_write_t;
endpackage : pm_msi_pkg
`default_nettype wire

/* File: core/port_power_mgmt_msi_regs.sv */
// per-port power management and message interrupt configuration registers
`default_nettype none
module port_power_mgmt_msi_regs #(
   parameter bit IS_UPSTREAM = 1'b0
) (
   // clock and resets
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    hot_rst_i,
   // wishbone slave
   input  wire logic                    cyc_i,
   input  wire logic                    stb_i,
   input  wire logic                    we_i,
   input  wire logic [7:0]              adr_i,
   input  wire logic [3:0]              sel_i,
   input  wire logic [31:0]             dat_i,
   output logic      [31:0]             dat_o,
   output logic                         ack_o,
   // port events
   input  wire logic                    own_wake_event_i,
   input  wire logic                    fwd_wake_event_i,
   input  wire logic                    irq_event_i,
   // outputs
   output logic                         wake_msg_req_o,
   output logic                         fwd_wake_msg_o,
   output logic      [1:0]              power_state_o,
   output logic                         context_keep_o,
   output pm_msi_pkg::msg_write_t       msg_write_o,
   output logic                         route_upstream_o
);

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // only full-on and hot-off are kept by the power state field
   function automatic logic legal_state(input logic [1:0] st);
      return (st == pm_msi_pkg::STATE_FULL_ON) || (st == pm_msi_pkg::STATE_HOT_OFF);
   endfunction : legal_state

   // offsets that answer with register contents
   function automatic logic is_mapped(input logic [7:0] a);
      logic hit;
      hit = (a == pm_msi_pkg::OFS_POWER_CTRL_STATUS);
      hit = hit || (a == pm_msi_pkg::OFS_IRQ_MSG_CAP_CTRL);
      hit = hit || (a == pm_msi_pkg::OFS_IRQ_MSG_LOWER_ADDR);
      hit = hit || (a == pm_msi_pkg::OFS_IRQ_MSG_UPPER_ADDR);
      hit = hit || (a == pm_msi_pkg::OFS_IRQ_MSG_PAYLOAD);
      return hit;
   endfunction : is_mapped

   logic [1:0]  power_state_sel_ff;
   logic        context_keep_flag_ff;
   logic        wake_msg_enable_ff;
   logic        wake_msg_flag_ff;
   logic        irq_enable_ff;
   logic [29:0] lower_addr_ff;
   logic [31:0] upper_message_address_ff;
   logic [15:0] message_payload_ff;
   logic [31:0] dat_ff;
   logic        ack_ff;
   pm_msi_pkg::msg_write_t msg_ff;
   logic        wake_req_ff;
   logic        fwd_ff;
   logic        route_ff;

   logic [1:0]  nxt_power_state_sel;
   logic        nxt_context_keep_flag;
   logic        nxt_wake_msg_enable;
   logic        nxt_wake_msg_flag;
   logic        nxt_irq_enable;
   logic [29:0] nxt_lower_addr;
   logic [31:0] nxt_upper_message_address;
   logic [15:0] nxt_message_payload;
   logic [31:0] nxt_dat;
   logic        nxt_ack;
   pm_msi_pkg::msg_write_t nxt_msg;
   logic        nxt_wake_req;
   logic        nxt_fwd;
   logic        nxt_route;

   logic        wr;
   logic [31:0] pcs_rd;
   logic [31:0] cap_rd;
   logic [31:0] low_rd;
   logic [31:0] wv;
   logic        own_event;

   ////////////////////////////////////////////////////////////////////////
   assign wr        = cyc_i && stb_i && we_i && !ack_ff;
   assign own_event = own_wake_event_i && !IS_UPSTREAM;

   always_comb begin
      pcs_rd = 32'h0000_0000;
      pcs_rd[pm_msi_pkg::POS_POWER_STATE +: 2] = power_state_sel_ff;
      pcs_rd[pm_msi_pkg::POS_CONTEXT_KEEP]     = context_keep_flag_ff;
      pcs_rd[pm_msi_pkg::POS_WAKE_ENABLE]      = wake_msg_enable_ff;
      pcs_rd[pm_msi_pkg::POS_WAKE_FLAG]        = wake_msg_flag_ff;
      cap_rd = {8'h00, pm_msi_pkg::WIDE_ADDRESS_CAPABLE, pm_msi_pkg::MULTI_MSG_ENABLE,
                pm_msi_pkg::MULTI_MSG_CAPABLE, irq_enable_ff,
                pm_msi_pkg::NEXT_CAPABILITY_LINK,
                pm_msi_pkg::CAPABILITY_IDENTIFIER};
      low_rd = {lower_addr_ff, 2'h0};
   end

   ////////////////////////////////////////////////////////////////////////
   // register writes and status
   always_comb begin
      nxt_power_state_sel       = power_state_sel_ff;
      nxt_context_keep_flag     = context_keep_flag_ff;
      nxt_wake_msg_enable       = wake_msg_enable_ff;
      nxt_wake_msg_flag         = wake_msg_flag_ff;
      nxt_irq_enable            = irq_enable_ff;
      nxt_lower_addr            = lower_addr_ff;
      nxt_upper_message_address = upper_message_address_ff;
      nxt_message_payload       = message_payload_ff;
      wv                        = 32'h0000_0000;
      if (wr) begin
         unique case (adr_i)
            pm_msi_pkg::OFS_POWER_CTRL_STATUS: begin
               wv = merge(pcs_rd, dat_i, sel_i);
               if (legal_state(wv[1:0])) begin
                  nxt_power_state_sel = wv[1:0];
               end
               nxt_context_keep_flag = wv[pm_msi_pkg::POS_CONTEXT_KEEP];
               nxt_wake_msg_enable   = wv[pm_msi_pkg::POS_WAKE_ENABLE];
               if (sel_i[1] && dat_i[pm_msi_pkg::POS_WAKE_FLAG]) begin
                  nxt_wake_msg_flag = 1'b0;
               end
            end
            pm_msi_pkg::OFS_IRQ_MSG_CAP_CTRL: begin
               wv = merge(cap_rd, dat_i, sel_i);
               nxt_irq_enable = wv[pm_msi_pkg::POS_IRQ_ENABLE];
            end
            pm_msi_pkg::OFS_IRQ_MSG_LOWER_ADDR: begin
               wv = merge(low_rd, dat_i, sel_i);
               nxt_lower_addr = wv[31:2];
            end
            pm_msi_pkg::OFS_IRQ_MSG_UPPER_ADDR: begin
               nxt_upper_message_address = merge(upper_message_address_ff, dat_i, sel_i);
            end
            pm_msi_pkg::OFS_IRQ_MSG_PAYLOAD: begin
               wv = merge({16'h0000, message_payload_ff}, dat_i, sel_i);
               nxt_message_payload = wv[15:0];
            end
            default: begin
               wv = 32'h0000_0000;
            end
         endcase
      end
      if (own_event) begin
         nxt_wake_msg_flag = 1'b1;
      end
   end

   // sticky bits survive hot reset; the rest go to default
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_msg_enable_ff <= 1'b0;
         wake_msg_flag_ff   <= 1'b0;
      end else begin
         wake_msg_enable_ff <= nxt_wake_msg_enable;
         wake_msg_flag_ff   <= nxt_wake_msg_flag;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || hot_rst_i) begin
         power_state_sel_ff       <= pm_msi_pkg::STATE_FULL_ON;
         context_keep_flag_ff     <= pm_msi_pkg::RST_CONTEXT_KEEP;
         irq_enable_ff            <= 1'b0;
         lower_addr_ff            <= 30'h0000_0000;
         upper_message_address_ff <= 32'h0000_0000;
         message_payload_ff       <= 16'h0000;
      end else begin
         power_state_sel_ff       <= nxt_power_state_sel;
         context_keep_flag_ff     <= nxt_context_keep_flag;
         irq_enable_ff            <= nxt_irq_enable;
         lower_addr_ff            <= nxt_lower_addr;
         upper_message_address_ff <= nxt_upper_message_address;
         message_payload_ff       <= nxt_message_payload;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus answer: ack one cycle after request, dropped the cycle after
   always_comb begin
      nxt_ack = cyc_i && stb_i && !ack_ff;
      nxt_dat = 32'h0000_0000;
      if (cyc_i && stb_i && !we_i && !ack_ff) begin
         unique case (adr_i)
            pm_msi_pkg::OFS_POWER_CTRL_STATUS:  nxt_dat = pcs_rd;
            pm_msi_pkg::OFS_IRQ_MSG_CAP_CTRL:   nxt_dat = cap_rd;
            pm_msi_pkg::OFS_IRQ_MSG_LOWER_ADDR: nxt_dat = low_rd;
            pm_msi_pkg::OFS_IRQ_MSG_UPPER_ADDR: nxt_dat = upper_message_address_ff;
            pm_msi_pkg::OFS_IRQ_MSG_PAYLOAD:    nxt_dat = {16'h0000, message_payload_ff};
            default:                            nxt_dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= nxt_ack;
         dat_ff <= nxt_dat;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // message write and wake requests
   always_comb begin
      nxt_msg       = '0;
      nxt_msg.valid = irq_event_i && irq_enable_ff;
      nxt_msg.wide  = (upper_message_address_ff != 32'h0000_0000);
      nxt_msg.addr  = nxt_msg.wide ? {upper_message_address_ff, lower_addr_ff, 2'h0}
                                   : {32'h0000_0000, lower_addr_ff, 2'h0};
      nxt_msg.data  = {16'h0000, message_payload_ff};
      nxt_wake_req  = own_event && wake_msg_enable_ff;
      nxt_fwd       = fwd_wake_event_i;
      nxt_route     = nxt_msg.valid && !IS_UPSTREAM;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         msg_ff      <= '0;
         wake_req_ff <= 1'b0;
         fwd_ff      <= 1'b0;
         route_ff    <= 1'b0;
      end else begin
         msg_ff      <= nxt_msg;
         wake_req_ff <= nxt_wake_req;
         fwd_ff      <= nxt_fwd;
         route_ff    <= nxt_route;
      end
   end

   assign dat_o            = dat_ff;
   assign ack_o            = ack_ff;
   assign msg_write_o      = msg_ff;
   assign wake_msg_req_o   = wake_req_ff;
   assign fwd_wake_msg_o   = fwd_ff;
   assign power_state_o    = power_state_sel_ff;
   assign context_keep_o   = context_keep_flag_ff;
   assign route_upstream_o = route_ff;

   ////////////////////////////////////////////////////////////////////////
   sequence s_wr_pcs;
      wr && adr_i == pm_msi_pkg::OFS_POWER_CTRL_STATUS && sel_i[1];
   endsequence

   // request taken this cycle, answered in the next
   sequence s_bus_req;
      cyc_i && stb_i && !ack_ff;
   endsequence

   sequence s_rd_pcs;
      s_bus_req ##0 (!we_i && adr_i == pm_msi_pkg::OFS_POWER_CTRL_STATUS);
   endsequence

   sequence s_rd_low;
      s_bus_req ##0 (!we_i && adr_i == pm_msi_pkg::OFS_IRQ_MSG_LOWER_ADDR);
   endsequence

   sequence s_rd_other;
      s_bus_req ##0 (!we_i && !is_mapped(adr_i));
   endsequence

   AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      own_event |=> wake_msg_flag_ff) else $error("event flag not set");
   AST_FLAG_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
      s_wr_pcs ##0 (dat_i[pm_msi_pkg::POS_WAKE_FLAG] && !own_event) |=> !wake_msg_flag_ff)
      else $error("flag not cleared");
   AST_FWD_NOSET: assert property (@(posedge clk_i) disable iff (rst_i)
      !wake_msg_flag_ff && !own_wake_event_i |=> !wake_msg_flag_ff) else $error("flag set by fwd");
   AST_UP_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      IS_UPSTREAM |-> ##1 !wake_msg_flag_ff) else $error("upstream flag set");
   AST_HOT_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
      hot_rst_i && !wr |=> $stable(wake_msg_enable_ff)) else $error("hot reset");
   AST_STATE_LEGAL: assert property (@(posedge clk_i) disable iff (rst_i)
      legal_state(power_state_sel_ff)) else $error("bad power state");
   AST_CAP_RD: assert property (@(posedge clk_i) disable iff (rst_i)
      cyc_i && stb_i && !we_i && !ack_ff && adr_i == pm_msi_pkg::OFS_IRQ_MSG_CAP_CTRL
      |=> ack_o && dat_o[7:0] == 8'h05 && dat_o[23] && dat_o[22:17] == 6'h00)
      else $error("capability read wrong");
   AST_MSG_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
      msg_write_o.valid |-> $past(irq_enable_ff) && $past(irq_event_i)) else $error("msg ungated");
   AST_WIDE: assert property (@(posedge clk_i) disable iff (rst_i)
      msg_write_o.valid |-> msg_write_o.wide == (msg_write_o.addr[63:32] != 32'h0))
      else $error("address width wrong");
   AST_LOW_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      msg_write_o.addr[1:0] == 2'h0) else $error("low address bits set");

   // register reads
   AST_PCS_RSVD: assert property (@(posedge clk_i) disable iff (rst_i)
      s_rd_pcs |=> dat_o[31:16] == 16'h0000 && dat_o[14:9] == 6'h00 && dat_o[7:4] == 4'h0
                   && !dat_o[2]) else $error("power control reserved bits set");
   AST_LOW_RD: assert property (@(posedge clk_i) disable iff (rst_i)
      s_rd_low |=> ack_o && dat_o[1:0] == 2'h0) else $error("lower address bits set");
   AST_UNMAPPED_RD: assert property (@(posedge clk_i) disable iff (rst_i)
      s_rd_other |=> ack_o && dat_o == 32'h0000_0000) else $error("unmapped read not zero");

   // wake requests and hot reset
   AST_WAKE_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
      own_event && wake_msg_enable_ff |=> wake_msg_req_o) else $error("wake request missing");
   AST_WAKE_MUTE: assert property (@(posedge clk_i) disable iff (rst_i)
      !wake_msg_enable_ff |=> !wake_msg_req_o) else $error("wake request while disabled");
   AST_FWD_PASS: assert property (@(posedge clk_i) disable iff (rst_i)
      fwd_wake_event_i |=> fwd_wake_msg_o) else $error("forwarded event lost");
   AST_HOT_FLAG: assert property (@(posedge clk_i) disable iff (rst_i)
      hot_rst_i && !wr && !own_event |=> $stable(wake_msg_flag_ff)) else $error("flag lost");
   AST_HOT_STATE: assert property (@(posedge clk_i) disable iff (rst_i)
      hot_rst_i |=> power_state_o == pm_msi_pkg::STATE_FULL_ON) else $error("state kept");
   AST_HOT_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
      hot_rst_i |=> !irq_enable_ff) else $error("interrupt enable kept");

   // message writes
   AST_IRQ_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
      !irq_enable_ff |=> !msg_write_o.valid) else $error("message while disabled");
   AST_MSG_FIRE: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_event_i && irq_enable_ff |=> msg_write_o.valid) else $error("message missing");
   AST_PAYLOAD: assert property (@(posedge clk_i) disable iff (rst_i)
      msg_write_o.valid |-> msg_write_o.data == {16'h0000, $past(message_payload_ff)})
      else $error("message payload wrong");
   AST_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
      msg_write_o.valid |-> route_upstream_o == !IS_UPSTREAM) else $error("route wrong");
   AST_UP_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
      IS_UPSTREAM |-> !route_upstream_o) else $error("upstream port routes upward");

endmodule : port_power_mgmt_msi_regs
`default_nettype wire

/* File: tb/msg_sink.sv */
// upstream receiver model that captures interrupt message writes
`default_nettype none
module msg_sink (
   // clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   // message write from the port
   input  wire pm_msi_pkg::msg_write_t msg_i,
   input  wire logic                   route_i,
   // captured traffic
   output var int                      count_o,
   output pm_msi_pkg::msg_write_t      last_o,
   output logic                        route_o
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////////////////
   // one capture for each cycle in which valid stands
   always @(posedge clk_i) begin
      if (rst_i) begin
         count_o <= 0;
      end else if (msg_i.valid === 1'h1) begin
         count_o <= count_o + 1;
         last_o  <= msg_i;
         route_o <= route_i;
      end
   end
endmodule : msg_sink
`default_nettype wire

/* File: tb/port_power_mgmt_msi_regs_bench.sv */
// register bank bench: wishbone accesses, port events and message writes
`default_nettype none
module port_power_mgmt_msi_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                   clk_i     = 1'h0;
   logic                   rst_i     = 1'h1;
   logic                   hot_rst_i = 1'h0;
   logic                   cyc_i     = 1'h0;
   logic                   stb_i     = 1'h0;
   logic                   we_i      = 1'h0;
   logic [7:0]             adr_i     = 8'h00;
   logic [3:0]             sel_i     = 4'h0;
   logic [31:0]            dat_i     = 32'h0;
   logic [2:0]             ev        = 3'h0;
   logic [31:0]            dat_o;
   logic                   ack_o;
   logic                   wake_msg_req_o;
   logic                   fwd_wake_msg_o;
   logic [1:0]             power_state_o;
   logic                   context_keep_o;
   logic                   route_upstream_o;
   logic                   last_route;
   logic [31:0]            up_dat;
   logic [31:0]            up_q;
   logic                   up_wake;
   pm_msi_pkg::msg_write_t msg_write_o;
   pm_msi_pkg::msg_write_t last_msg;
   int                     msg_count;
   int                     fails = 0;
   int                     samples_checked = 0;
   int                     cycles = 0;

   port_power_mgmt_msi_regs u_dut (
      .clk_i, .rst_i, .hot_rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o, .ack_o, .own_wake_event_i(ev[0]), .fwd_wake_event_i(ev[1]),
      .irq_event_i(ev[2]), .wake_msg_req_o, .fwd_wake_msg_o, .power_state_o,
      .context_keep_o, .msg_write_o, .route_upstream_o
   );
   msg_sink u_sink (
      .clk_i, .rst_i, .msg_i(msg_write_o), .route_i(route_upstream_o),
      .count_o(msg_count), .last_o(last_msg), .route_o(last_route)
   );
   // upstream copy on the same bus; its event flag must stay clear
   port_power_mgmt_msi_regs #(.IS_UPSTREAM(1'b1)) u_up (
      .clk_i, .rst_i, .hot_rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o(up_dat), .ack_o(), .own_wake_event_i(ev[0]), .fwd_wake_event_i(ev[1]),
      .irq_event_i(ev[2]), .wake_msg_req_o(up_wake), .fwd_wake_msg_o(), .power_state_o(),
      .context_keep_o(), .msg_write_o(), .route_upstream_o()
   );

   always #10 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////////////////
   task conclude;
      if (fails == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails = fails + 1;
         conclude();
      end
   end

   task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : check

   // classic cycle held until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
      @(posedge clk_i);
      cyc_i <= 1'h1;
      stb_i <= 1'h1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= s;
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'h1);
      q    = dat_o;
      up_q = up_dat;
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
      we_i  <= 1'h0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] q;
      bus(1'h1, a, d, s, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'h0, a, 32'h0, 4'hF, q);
      check($sformatf("read of %0h", a), q, e);
   endtask : rd

   // pulse ends at a falling edge, where the one-cycle reply stands
   task automatic pulse(input int k);
      @(posedge clk_i);
      ev[k] <= 1'h1;
      @(posedge clk_i);
      ev[k] <= 1'h0;
      @(negedge clk_i);
   endtask : pulse

   task automatic rst_pulse(input logic hot);
      @(posedge clk_i);
      if (hot) hot_rst_i <= 1'h1;
      else rst_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      hot_rst_i <= 1'h0;
      rst_i     <= 1'h0;
   endtask : rst_pulse

   task automatic msg(input logic [63:0] a, input logic w, input int n);
      pulse(2);
      @(negedge clk_i);
      check("message count", msg_count, n);
      check("message address", last_msg.addr, a);
      check("message wide", last_msg.wide, w);
      check("message payload", last_msg.data[15:0], 16'hA5C3);
      check("message route", last_route, 1'h1);
   endtask : msg
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'h0;
      check("power_state_o", power_state_o, 2'h0);
      check("context_keep_o", context_keep_o, 1'h1);
      rd(8'hC4, 32'h0000_0008);
      rd(8'hD0, 32'h0080_0005);
      rd(8'hD4, 32'h0000_0000);
      wr(8'hC4, 32'hFFFF_FFFF, 4'hF);
      rd(8'hC4, 32'h0000_010B);
      check("power_state_o", power_state_o, 2'h3);
      for (int i = 0; i < 4; i++) begin
         wr(8'hC4, 32'h0000_0108 | i, 4'hF);
         rd(8'hC4, 32'h0000_0108 | ((i == 3) ? 3 : 0));
      end
      pulse(0);
      check("wake_msg_req_o", wake_msg_req_o, 1'h1);
      check("upstream wake request", up_wake, 1'h0);
      rd(8'hC4, 32'h0000_810B);
      check("upstream event flag", up_q[15], 1'h0);
      wr(8'hC4, 32'h0000_800B, 4'h1);
      rd(8'hC4, 32'h0000_810B);
      wr(8'hC4, 32'h0000_810B, 4'hF);
      rd(8'hC4, 32'h0000_010B);
      pulse(1);
      check("fwd_wake_msg_o", fwd_wake_msg_o, 1'h1);
      check("wake_msg_req_o", wake_msg_req_o, 1'h0);
      rd(8'hC4, 32'h0000_010B);
      wr(8'hC4, 32'h0000_000B, 4'hF);
      pulse(0);
      check("wake_msg_req_o", wake_msg_req_o, 1'h0);
      rd(8'hC4, 32'h0000_800B);
      wr(8'hC4, 32'h0000_0103, 4'hF);
      check("context_keep_o", context_keep_o, 1'h0);
      rst_pulse(1'h1);
      rd(8'hC4, 32'h0000_8108);
      rst_pulse(1'h0);
      rd(8'hC4, 32'h0000_0008);
      wr(8'hC4, 32'h0000_0100, 4'h2);
      rd(8'hC4, 32'h0000_0108);
      wr(8'hD0, 32'hFFFF_FFFF, 4'hF);
      rd(8'hD0, 32'h0081_0005);
      wr(8'hD4, 32'hFFFF_FFFF, 4'hF);
      rd(8'hD4, 32'hFFFF_FFFC);
      wr(8'hDC, 32'hFFFF_A5C3, 4'hF);
      msg(64'h0000_0000_FFFF_FFFC, 1'h0, 1);
      wr(8'hD8, 32'h0000_0012, 4'hF);
      msg(64'h0000_0012_FFFF_FFFC, 1'h1, 2);
      wr(8'hD0, 32'h0000_0000, 4'hF);
      msg(64'h0000_0012_FFFF_FFFC, 1'h1, 2);
      wr(8'h10, 32'hFFFF_FFFF, 4'hF);
      rd(8'h10, 32'h0000_0000);
      conclude();
   end
endmodule : port_power_mgmt_msi_regs_bench
`default_nettype wire
